// *** ext_bus_ctrl.sv ***
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module ext_bus_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // cpu side
  input wire ext_bus_pkg::bus_req_t req,
  output logic busy,
  output logic done,
  output logic internal_rom,
  output logic [`DATA_W-1:0] rdata,
  output logic rom_mapped,
  // pins in
  input wire logic ready,
  input wire logic hold_req_n,
  input wire logic out_float_n,
  input wire logic rom_map_select,
  input wire logic [`DATA_W-1:0] data_in,
  // pins out
  output ext_bus_pkg::bus_pins_t pins
);
  import ext_bus_pkg::*;

  bus_regs_t r;
  bus_regs_t next_r;
  logic ready_s;
  logic hold_s;
  logic float_s;
  logic rom_hit;

  always_comb begin
    next_r = r;
    // second stage only feeds logic
    ready_s = r.ready_sync[1];
    hold_s = ~r.hold_sync[1];
    float_s = ~r.float_sync[1];
    next_r.ready_sync = {r.ready_sync[1], r.ready_sync[0], ready};
    next_r.hold_sync = {r.hold_sync[0], hold_req_n};
    next_r.float_sync = {r.float_sync[0], out_float_n};
    next_r.map_sync = {r.map_sync[0], rom_map_select};
    next_r.done = 1'b0;
    // map latched after both sync stages
    if (r.rst_seen != `START_DONE) begin
      next_r.rst_seen = r.rst_seen + `START_STEP;
    end
    if (r.rst_seen == `MAP_CAPTURE_STEP) begin
      next_r.rom_mapped = ~r.map_sync[1];
    end
    rom_hit = r.rom_mapped && req.space == SPACE_PROG &&
      req.addr[`LOW_ADDR_W-1:`LOW_ADDR_W-2] == `ROM_BASE_HI;
    next_r.internal_rom = 1'b0;
    unique case (r.state)
      ST_IDLE: begin
        next_r.busy = 1'b0;
        next_r.pins.microstate_done_n = 1'b1;
        if (hold_s) begin
          next_r.state = ST_HOLD;
          next_r.pins.addr_oe = 1'b0;
          next_r.pins.data_oe = 1'b0;
          next_r.pins.ctrl_oe = 1'b0;
        end else if (req.valid && rom_hit) begin
          next_r.internal_rom = 1'b1;
          next_r.done = 1'b1;
        end else if (req.valid && r.rst_seen == `START_DONE) begin
          next_r.busy = 1'b1;
          // upper lines only for program space
          next_r.pins.addr = (req.space == SPACE_PROG) ? req.addr :
            {{(`ADDR_W-`LOW_ADDR_W){1'b0}}, req.addr[`LOW_ADDR_W-1:0]};
          next_r.pins.data_space_select_n = req.space != SPACE_DATA;
          next_r.pins.program_space_select_n = req.space != SPACE_PROG;
          next_r.pins.io_space_select_n = req.space != SPACE_IO;
          next_r.pins.memory_strobe_n = req.space == SPACE_IO;
          next_r.pins.io_device_strobe_n = req.space != SPACE_IO;
          next_r.pins.rw = ~req.write;
          next_r.pins.data_oe = req.write;
          next_r.pins.data_out = req.wdata;
          // ready used only with two or more waits
          next_r.ready_on = req.waits >= `TWO_WAIT;
          next_r.wait_left = req.waits;
          if (req.waits == `ZERO_WAIT) begin
            next_r.state = ST_READY;
          end else begin
            next_r.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        next_r.wait_left = r.wait_left - `ONE_WAIT;
        next_r.pins.microstate_done_n = ~(r.ready_on && r.wait_left == `TWO_WAIT);
        if (r.wait_left == `ONE_WAIT) begin
          next_r.state = ST_READY;
          next_r.wait_left = r.ready_on ? `SYNC_LAG : `ZERO_WAIT;
        end
      end
      ST_READY: begin
        next_r.pins.microstate_done_n = 1'b1;
        // sync lag aligns ready with the last wait
        if (r.wait_left != `ZERO_WAIT) begin
          next_r.wait_left = `ZERO_WAIT;
        // sample ready after the waits; low means one more cycle
        end else if (!r.ready_on || ready_s) begin
          next_r.state = ST_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.rdata = data_in;
          next_r.pins.data_space_select_n = 1'b1;
          next_r.pins.program_space_select_n = 1'b1;
          next_r.pins.io_space_select_n = 1'b1;
          next_r.pins.memory_strobe_n = 1'b1;
          next_r.pins.io_device_strobe_n = 1'b1;
          next_r.pins.rw = 1'b1;
          next_r.pins.data_oe = 1'b0;
        end
      end
      ST_HOLD: begin
        next_r.pins.bus_grant_ack_n = 1'b0;
        if (!hold_s) begin
          next_r.state = ST_IDLE;
          next_r.pins.bus_grant_ack_n = 1'b1;
          next_r.pins.addr_oe = 1'b1;
          next_r.pins.ctrl_oe = 1'b1;
        end
      end
    endcase
    // float controls in hold or when forced
    if (float_s) begin
      next_r.pins.ctrl_oe = 1'b0;
      next_r.pins.addr_oe = 1'b0;
      next_r.pins.data_oe = 1'b0;
      next_r.pins.misc_oe = 1'b0;
    end else begin
      next_r.pins.misc_oe = 1'b1;
      if (r.state != ST_HOLD && next_r.state != ST_HOLD) begin
        next_r.pins.ctrl_oe = 1'b1;
        next_r.pins.addr_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.ready_sync <= 3'h7;
      r.hold_sync <= 2'h3;
      r.float_sync <= 2'h3;
      r.pins.data_space_select_n <= 1'b1;
      r.pins.program_space_select_n <= 1'b1;
      r.pins.io_space_select_n <= 1'b1;
      r.pins.memory_strobe_n <= 1'b1;
      r.pins.io_device_strobe_n <= 1'b1;
      r.pins.rw <= 1'b1;
      r.pins.bus_grant_ack_n <= 1'b1;
      r.pins.microstate_done_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.busy;
  assign done = r.done;
  assign internal_rom = r.internal_rom;
  assign rdata = r.rdata;
  assign rom_mapped = r.rom_mapped;
  assign pins = r.pins;
endmodule

// *** ext_bus_defines.svh ***
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
// Summary of operation
// - Each space select rests high and only the one for the accessed space goes low while the address is valid.
// - In hold the space selects, memory strobe, io strobe and direction line are released.
// - The memory strobe rests high and goes low only on an external program or data memory access.
// - The io strobe rests high and goes low only on an external io access.
// - The direction line rests high for read and goes low only during an external write.
// - While ready is seen low the access waits one cycle and samples ready again.
// - Ready is looked at only with two or more wait states programmed and only after they have all elapsed.
// - A bus request from an outside master is granted by floating address, data and control lines.
// - Hold acknowledge is given only while in the hold state with the lines floated.
// - With two or more wait states programmed, microstate done goes low during the last one.
// - Microstate done looped to ready yields exactly one extra external wait state.
// - A low output float input releases selects, strobes, direction, hold acknowledge and microstate done.
// - With the map pin low at reset the internal rom covers program addresses whose low 16 bits are C000 to FFFF, in every 64K page.
// - In microprocessor mode those program addresses go to the external bus.
// - The address bus floats in hold, and the data bus floats unless write data is driven, or in hold or reset.
// - Sixteen low address lines serve all spaces; the seven upper lines extend program space only.
`define ADDR_W 23
`define LOW_ADDR_W 16
`define DATA_W 16
`define WAIT_W 3
`define ROM_BASE_HI 2'h3
`define ZERO_WAIT 3'h0
`define ONE_WAIT 3'h1
`define TWO_WAIT 3'h2
`define SYNC_LAG 3'h1
`define START_STEP 2'h1
`define MAP_CAPTURE_STEP 2'h2
`define START_DONE 2'h3
`endif

// *** ext_bus_pkg.sv ***
`include "ext_bus_defines.svh"
package ext_bus_pkg;
  typedef enum logic [1:0] {SPACE_DATA, SPACE_PROG, SPACE_IO} space_t;
  typedef enum {ST_IDLE, ST_WAIT, ST_READY, ST_HOLD} bus_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    space_t space;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic [`WAIT_W-1:0] waits;
  } bus_req_t;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data_out;
    logic data_oe;
    logic addr_oe;
    logic ctrl_oe;
    logic data_space_select_n;
    logic program_space_select_n;
    logic io_space_select_n;
    logic memory_strobe_n;
    logic io_device_strobe_n;
    logic rw;
    logic bus_grant_ack_n;
    logic microstate_done_n;
    logic misc_oe;
  } bus_pins_t;
  typedef struct packed {
    bus_state_t state;
    logic [`WAIT_W-1:0] wait_left;
    logic ready_on;
    logic rom_mapped;
    logic [1:0] rst_seen;
    logic busy;
    logic done;
    logic internal_rom;
    logic [`DATA_W-1:0] rdata;
    logic [2:0] ready_sync;
    logic [1:0] hold_sync;
    logic [1:0] float_sync;
    logic [1:0] map_sync;
    bus_pins_t pins;
  } bus_regs_t;
endpackage

// *** ext_bus_checker_assertions.sv ***
`timescale 1ns/1ps
module ext_bus_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic busy,
  input wire logic done,
  input wire logic internal_rom,
  input wire logic out_float_n,
  input wire ext_bus_pkg::bus_pins_t pins
);
  import ext_bus_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_one_select: assert property ($countones({pins.data_space_select_n, pins.program_space_select_n,
    pins.io_space_select_n}) >= 2) else $error("two selects low");
  a_idle_high: assert property (!busy && !done && pins.ctrl_oe |-> &{pins.data_space_select_n,
    pins.program_space_select_n, pins.io_space_select_n, pins.memory_strobe_n, pins.io_device_strobe_n, pins.rw})
    else $error("idle control low");
  a_mem_strobe: assert property (!pins.memory_strobe_n |-> pins.io_space_select_n && busy)
    else $error("memory strobe off access");
  a_io_strobe: assert property (!pins.io_device_strobe_n |-> !pins.io_space_select_n && busy)
    else $error("io strobe off access");
  a_write_dir: assert property (pins.data_oe |-> !pins.rw && busy) else $error("data driven off write");
  a_hold_float: assert property (!pins.bus_grant_ack_n |-> !pins.ctrl_oe && !pins.addr_oe && !pins.data_oe)
    else $error("lines driven in hold");
  a_float_pins: assert property (!out_float_n [*4] |-> !pins.ctrl_oe && !pins.misc_oe)
    else $error("control driven while float");
  a_msc_in_wait: assert property (!pins.microstate_done_n |-> busy && !done) else $error("msc outside wait");
  a_rom_local: assert property (internal_rom |-> done && pins.program_space_select_n)
    else $error("rom hit on bus");
endmodule
bind ext_bus_ctrl ext_bus_checker ext_bus_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n), .busy(busy),
  .done(done), .internal_rom(internal_rom), .out_float_n(out_float_n), .pins(pins));

// *** ext_bus_partner.sv ***
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module ext_bus_partner (
  // clock and control
  input wire logic sys_clk,
  input wire logic [3:0] slow,
  input wire logic hold_go,
  // pins
  input wire ext_bus_pkg::bus_pins_t pins,
  output logic ready,
  output logic hold_req_n = 1'b1,
  output logic [`DATA_W-1:0] data_in
);
  import ext_bus_pkg::*;
  logic [3:0] age = 4'h0;
  logic [15:0] last = 16'h0;
  logic on;
  assign on = !pins.memory_strobe_n || !pins.io_device_strobe_n;
  assign ready = (slow == 4'hf) ? pins.microstate_done_n : on && age >= slow;
  // released bus shows inverse of last value
  assign data_in = (on && pins.rw) ? pins.addr[15:0] ^ 16'h5a5a : ~last;
  always @(posedge sys_clk) begin
    age <= on ? age + 4'h1 : 4'h0;
    if (on) last <= pins.addr[15:0] ^ 16'h5a5a;
    hold_req_n <= !(hold_go || (!hold_req_n && pins.bus_grant_ack_n));
  end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module tb_top;
  import ext_bus_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, out_float_n = 1'b1, rom_map_select = 1'b0, hold_go = 1'b0;
  logic busy, done, internal_rom, rom_mapped, ready, hold_req_n, saw_msc, hit;
  logic [`DATA_W-1:0] rdata, data_in;
  logic [3:0] slow = 4'h0;
  bus_req_t req = '0;
  bus_pins_t pins;
  int err_count = 0, n_checks = 0, cycles = 0, cnt, fast, n;
  always #12.5 sys_clk = ~sys_clk;
  ext_bus_ctrl ext_bus_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .busy(busy), .done(done),
    .internal_rom(internal_rom), .rdata(rdata), .rom_mapped(rom_mapped), .ready(ready), .hold_req_n(hold_req_n),
    .out_float_n(out_float_n), .rom_map_select(rom_map_select), .data_in(data_in), .pins(pins));
  ext_bus_partner ext_bus_partner_inst (.sys_clk(sys_clk), .slow(slow), .hold_go(hold_go), .pins(pins),
    .ready(ready), .hold_req_n(hold_req_n), .data_in(data_in));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(logic map);
    rom_map_select = map;
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic access(space_t sp, logic wr, logic [2:0] w, logic [22:0] a);
    req = '{valid: 1'b1, write: wr, space: sp, addr: a, wdata: ~a[15:0], waits: w};
    cnt = 0;
    saw_msc = 1'b0;
    do begin
      @(negedge sys_clk);
      cnt++;
      req.valid = 1'b0;
      if (pins.microstate_done_n === 1'b0) saw_msc = 1'b1;
      if (cnt == 1 && busy === 1'b1) check("addr", a, pins.addr);
      if (cnt == 1 && busy === 1'b1) check("strobes", {sp != SPACE_DATA, sp != SPACE_PROG, sp != SPACE_IO,
        sp == SPACE_IO, sp != SPACE_IO}, {pins.data_space_select_n, pins.program_space_select_n,
        pins.io_space_select_n, pins.memory_strobe_n, pins.io_device_strobe_n});
      if (cnt == 1 && busy === 1'b1 && wr) check("wdata", {1'b0, ~a[15:0]}, {pins.rw, pins.data_out});
    end while (done !== 1'b1 && cnt < 40);
    hit = internal_rom;
    if (!wr && !hit) check("rdata", a[15:0] ^ 16'h5a5a, rdata);
    @(negedge sys_clk);
  endtask
  task automatic t_spaces();
    for (int s = 0; s < 3; s++) for (int wr = 0; wr < 2; wr++) begin
      access(space_t'(s), wr[0], 3'h0, 23'h001230 + s);
      check("cycles", 2, cnt);
    end
  endtask
  task automatic t_waits();
    for (int w = 0; w < 4; w++) begin
      slow = 4'h0;
      access(SPACE_DATA, 1'b0, w[2:0], 23'h000400);
      fast = cnt;
      // one more cycle with ready in use: sync lag
      check("fast", w < 2 ? w + 2 : w + 3, fast);
      check("msc", w >= 2, saw_msc);
      slow = 4'h6;
      access(SPACE_DATA, 1'b0, w[2:0], 23'h000400);
      check("slow", 1, w < 2 ? cnt == fast : cnt > fast);
      if (w >= 2) begin
        slow = 4'hf;
        access(SPACE_DATA, 1'b0, w[2:0], 23'h000400);
        check("loop", fast + 1, cnt);
      end
    end
    slow = 4'h0;
  endtask
  task automatic t_hold();
    hold_go = 1'b1;
    n = 0;
    while (pins.bus_grant_ack_n !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (3) @(negedge sys_clk);
    check("hold", 4'h0, {pins.bus_grant_ack_n, pins.ctrl_oe, pins.addr_oe, pins.data_oe});
    hold_go = 1'b0;
    repeat (8) @(negedge sys_clk);
    check("release", 2'h3, {pins.bus_grant_ack_n, pins.ctrl_oe});
  endtask
  task automatic t_float();
    out_float_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    check("float", 2'h0, {pins.ctrl_oe, pins.misc_oe});
    out_float_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("driven", 2'h3, {pins.ctrl_oe, pins.misc_oe});
  endtask
  task automatic t_rom();
    check("mapped", 1, rom_mapped);
    access(SPACE_PROG, 1'b0, 3'h0, 23'h00c010);
    check("rom hit", 2'h3, {hit, cnt == 1});
    do_reset(1'b1);
    check("unmapped", 0, rom_mapped);
    access(SPACE_PROG, 1'b0, 3'h0, 23'h05c010);
    check("off chip", 2'h1, {hit, cnt == 2});
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    do_reset(1'b0);
    t_spaces();
    t_waits();
    t_hold();
    t_float();
    t_rom();
    report_and_stop();
  end
endmodule
